// File: logic/fsc_pkg.sv
// Package of the flash command host: op codes, command bytes and timing.
// Assumes a 50 MHz core clock; all counts are derived from it.
package fsc_pkg;
    // Host operations offered on the command port
    typedef enum logic [3:0] {
        OP_READ     = 4'h0,
        OP_RESET    = 4'h1,
        OP_PROGRAM  = 4'h2,
        OP_CHIP_ER  = 4'h3,
        OP_SECT_ER  = 4'h4,
        OP_SUSPEND  = 4'h5,
        OP_RESUME   = 4'h6,
        OP_AUTOSEL  = 4'h7,
        OP_SECURED  = 4'h8,
        OP_BYP_ENT  = 4'h9,
        OP_BYP_PROG = 4'hA,
        OP_BYP_EXIT = 4'hB,
        OP_HW_RESET = 4'hC
    } fsc_op_t;

    // One bus cycle of a command sequence
    typedef struct packed {
        logic        isRead;
        logic        last;
        logic [21:0] addr;
        logic [7:0]  data;
    } fsc_step_t;

    localparam int          ADDR_W       = 22;
    localparam logic [21:0] ADDR_DC      = 22'h000000; // Don't-care address
    localparam logic [7:0]  CMD_UNLOCK1  = 8'hAA;
    localparam logic [7:0]  CMD_UNLOCK2  = 8'h55;
    localparam logic [7:0]  CMD_RESET    = 8'hF0;
    localparam logic [7:0]  CMD_PROG     = 8'hA0;
    localparam logic [7:0]  CMD_ERASE    = 8'h80;
    localparam logic [7:0]  CMD_CHIP     = 8'h10;
    localparam logic [7:0]  CMD_SECTOR   = 8'h30;
    localparam logic [7:0]  CMD_SUSPEND  = 8'hB0;
    localparam logic [7:0]  CMD_RESUME   = 8'h30;
    localparam logic [7:0]  CMD_AUTOSEL  = 8'h90;
    localparam logic [7:0]  CMD_SECURED  = 8'h88;
    localparam logic [7:0]  CMD_BYPASS   = 8'h20;
    localparam logic [7:0]  CMD_BYP_EXIT = 8'h90;
    localparam logic [7:0]  CMD_BYP_ZERO = 8'h00;

    // Timing, figures in their own unit, counts derived from the clock
    localparam int CLK_NS     = 20;
    localparam int WE_LOW_NS  = 60;   // Least write strobe width
    localparam int RD_ACC_NS  = 100;  // Least read access time
    localparam int SUSP_US    = 20;   // Longest suspend latency
    localparam int RST_LOW_NS = 500;  // Least hardware reset pulse
    localparam int SYNC_STG   = 2;
    localparam logic [10:0] WE_CYC =
        11'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [10:0] RD_CYC =
        11'((RD_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STG);
    localparam logic [10:0] SUSP_CYC =
        11'((SUSP_US * 1000 + CLK_NS - 1) / CLK_NS);
    localparam logic [10:0] RST_CYC =
        11'((RST_LOW_NS + CLK_NS - 1) / CLK_NS);
endpackage : fsc_pkg

// File: logic/fsc_cycle_if.sv
// Interface carrying one bus-cycle request from sequencer to pin engine.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
interface fsc_cycle_if;
    logic        reqValid;
    logic        reqRead;
    logic [21:0] reqAddr;
    logic [7:0]  reqData;
    logic        done;
    logic [7:0]  rdData;

    modport seq (output reqValid, reqRead, reqAddr, reqData,
                 input  done, rdData);
    modport eng (input  reqValid, reqRead, reqAddr, reqData,
                 output done, rdData);
endinterface : fsc_cycle_if

// File: logic/fsc_bus_cycle.sv
// Pin engine: runs one asynchronous write or read cycle on the flash pins.
// Assumes one request at a time; a new one only after done.
`timescale 1ns/100ps
module fsc_bus_cycle
    import fsc_pkg::*;
(
    input  logic         core_clk,
    input  logic         rst,
    fsc_cycle_if.eng     cyc,
    output logic [21:0]  flashAddr,
    input  logic [7:0]   dqIn,
    output logic [7:0]   dqOut,
    output logic         dqOeN,
    output logic         ceN,
    output logic         weN,
    output logic         oeN
);
    typedef enum logic [1:0] {
        CY_IDLE = 2'b00, CY_SETUP = 2'b01, CY_STROBE = 2'b10, CY_RECOV = 2'b11
    } fsc_cyc_st_t;

    fsc_cyc_st_t st_q, st_d;
    logic [10:0] cnt_q, cnt_d;
    logic        rd_q, rd_d;
    logic [21:0] addr_q, addr_d;
    logic [7:0]  wd_q, wd_d, rdat_q, rdat_d;
    logic        ceN_d, weN_d, oeN_d, oeDq_d, done_d;
    logic        ceN_q, weN_q, oeN_q, dqOeN_q, done_q;
    logic [7:0]  sync1_q, sync2_q;

    // Data pins come from another timing world: two stages before use
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
        end else begin
            sync1_q <= dqIn;
            sync2_q <= sync1_q;
        end
    end

    // Cycle sequencing: address set-up, strobe, then release and hold
    always_comb begin
        st_d = st_q; cnt_d = cnt_q; rd_d = rd_q; addr_d = addr_q;
        wd_d = wd_q; rdat_d = rdat_q; done_d = 1'b0;
        ceN_d = ceN_q; weN_d = weN_q; oeN_d = oeN_q; oeDq_d = dqOeN_q;
        case (st_q)
            CY_IDLE: begin
                if (cyc.reqValid) begin
                    rd_d   = cyc.reqRead;
                    addr_d = cyc.reqAddr;
                    wd_d   = cyc.reqData;
                    ceN_d  = 1'b0;
                    oeDq_d = cyc.reqRead; // Drive data only on writes
                    st_d   = CY_SETUP;
                end
            end
            CY_SETUP: begin
                weN_d = rd_q;
                oeN_d = ~rd_q;
                cnt_d = rd_q ? RD_CYC : WE_CYC;
                st_d  = CY_STROBE;
            end
            CY_STROBE: begin
                cnt_d = cnt_q - 11'h001;
                if (cnt_q == 11'h001) begin
                    // Sampled data already lags the pins by the sync depth
                    if (rd_q) rdat_d = sync2_q;
                    weN_d = 1'b1;
                    oeN_d = 1'b1;
                    st_d  = CY_RECOV;
                end
            end
            CY_RECOV: begin
                // Data held one cycle past the strobe edge, then released
                ceN_d  = 1'b1;
                oeDq_d = 1'b1;
                done_d = 1'b1;
                st_d   = CY_IDLE;
            end
            default: st_d = CY_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= CY_IDLE; cnt_q <= 11'h000; rd_q <= 1'b0;
            addr_q <= 22'h000000; wd_q <= 8'h00; rdat_q <= 8'h00;
            ceN_q <= 1'b1; weN_q <= 1'b1; oeN_q <= 1'b1;
            dqOeN_q <= 1'b1; done_q <= 1'b0;
        end else begin
            st_q <= st_d; cnt_q <= cnt_d; rd_q <= rd_d;
            addr_q <= addr_d; wd_q <= wd_d; rdat_q <= rdat_d;
            ceN_q <= ceN_d; weN_q <= weN_d; oeN_q <= oeN_d;
            dqOeN_q <= oeDq_d; done_q <= done_d;
        end
    end

    assign flashAddr  = addr_q;
    assign dqOut      = wd_q;
    assign dqOeN      = dqOeN_q;
    assign ceN        = ceN_q;
    assign weN        = weN_q;
    assign oeN        = oeN_q;
    assign cyc.done   = done_q;
    assign cyc.rdData = rdat_q;
endmodule : fsc_bus_cycle

// File: logic/fsc_host_ctrl.sv
// Host controller for a byte-wide parallel NOR flash: expands user
// operations into unlock and command cycles, waits out erase suspend.
// Assumes the flash pins are wired straight to the ports below.
//
// How it works
// - Suspend is one write of B0 at a don't-care address.
// - Resume is one write of 30 at any address.
// - Sequences open with AA, 55; a single F0 returns to array read.
// - Erase is AA,55,80,AA,55 then 10 chip or 30 at sector.
// - Autoselect is AA,55,90 at 0XXXXX, then a read at the offset.
// - Secured-region entry is AA, 55, 88.
// - Program is AA, 55, A0, then target address with byte.
// - Bypass: AA,55,20 to enter, A0 plus byte, 90 then 00 to leave.
`timescale 1ns/100ps
module fsc_host_ctrl
    import fsc_pkg::*;
(
    input  logic         core_clk,
    input  logic         rst,
    input  logic         cmdValid,
    input  logic [3:0]   cmdOp,
    input  logic [21:0]  cmdAddr,
    input  logic [7:0]   cmdData,
    output logic         cmdReady,
    output logic         rspValid,
    output logic         rspErr,
    output logic [7:0]   rspData,
    output logic         eraseSuspended,
    output logic         bypassActive,
    output logic [21:0]  flashAddr,
    input  logic [7:0]   dqIn,
    output logic [7:0]   dqOut,
    output logic         dqOeN,
    output logic         ceN,
    output logic         weN,
    output logic         oeN,
    output logic         flashRstN
);
    typedef enum logic [1:0] {
        HS_IDLE = 2'b00, HS_ISSUE = 2'b01, HS_WAIT = 2'b10, HS_DELAY = 2'b11
    } fsc_hst_st_t;

    fsc_cycle_if cyc ();

    fsc_hst_st_t st_q, st_d;
    fsc_op_t     op_q, op_d;
    logic [2:0]  idx_q, idx_d;
    logic [21:0] addr_q, addr_d;
    logic [7:0]  data_q, data_d, rdat_q, rdat_d;
    logic [10:0] cnt_q, cnt_d;
    logic        susp_q, susp_d, byp_q, byp_d;
    logic        ready_q, ready_d, rspV_q, rspV_d, err_q, err_d;
    logic        req_q, req_d, frst_q, frst_d;
    fsc_step_t   step;

    // One step of each command sequence; address don't-care drives zero
    function automatic fsc_step_t stepOf(fsc_op_t op, logic [2:0] i,
                                         logic [21:0] a, logic [7:0] d);
        fsc_step_t s;
        s = '{isRead: 1'b0, last: 1'b0, addr: ADDR_DC, data: CMD_UNLOCK1};
        if (i == 3'd1) s.data = CMD_UNLOCK2;
        case (op)
            OP_READ:    s = '{1'b1, 1'b1, a, 8'h00};
            OP_RESET:   s = '{1'b0, 1'b1, ADDR_DC, CMD_RESET};
            OP_SUSPEND: s = '{1'b0, 1'b1, ADDR_DC, CMD_SUSPEND};
            OP_RESUME:  s = '{1'b0, 1'b1, ADDR_DC, CMD_RESUME};
            OP_PROGRAM: begin
                if (i == 3'd2) s.data = CMD_PROG;
                if (i == 3'd3) s = '{1'b0, 1'b1, a, d};
            end
            OP_CHIP_ER, OP_SECT_ER: begin
                if (i == 3'd2) s.data = CMD_ERASE;
                if (i == 3'd4) s.data = CMD_UNLOCK2;
                if (i == 3'd5) begin
                    s.last = 1'b1;
                    s.data = (op == OP_CHIP_ER) ? CMD_CHIP : CMD_SECTOR;
                    s.addr = (op == OP_CHIP_ER) ? ADDR_DC : a;
                end
            end
            OP_AUTOSEL: begin
                if (i == 3'd2) s.data = CMD_AUTOSEL; // Top address bit zero
                if (i == 3'd3) s = '{1'b1, 1'b0, a, 8'h00};
                // Exit with reset; a suspended device stays suspended
                if (i == 3'd4) s = '{1'b0, 1'b1, ADDR_DC, CMD_RESET};
            end
            OP_SECURED: begin
                if (i == 3'd2) begin
                    s.data = CMD_SECURED;
                    s.last = 1'b1;
                end
            end
            OP_BYP_ENT: begin
                if (i == 3'd2) begin
                    s.data = CMD_BYPASS;
                    s.last = 1'b1;
                end
            end
            OP_BYP_PROG: s = (i == 3'd0) ? '{1'b0, 1'b0, ADDR_DC, CMD_PROG}
                                         : '{1'b0, 1'b1, a, d};
            OP_BYP_EXIT: s = (i == 3'd0)
                ? '{1'b0, 1'b0, ADDR_DC, CMD_BYP_EXIT}
                : '{1'b0, 1'b1, ADDR_DC, CMD_BYP_ZERO};
            default: s.last = 1'b1;
        endcase
        return s;
    endfunction : stepOf

    assign step = stepOf(op_q, idx_q, addr_q, data_q);

    // Sequencer: refuse what the device would not take, else issue cycles
    always_comb begin
        st_d = st_q; op_d = op_q; idx_d = idx_q; addr_d = addr_q;
        data_d = data_q; rdat_d = rdat_q; cnt_d = cnt_q;
        susp_d = susp_q; byp_d = byp_q; ready_d = ready_q;
        rspV_d = 1'b0; err_d = err_q; req_d = 1'b0; frst_d = frst_q;
        case (st_q)
            HS_IDLE: begin
                if (cmdValid && ready_q) begin
                    ready_d = 1'b0;
                    op_d    = fsc_op_t'(cmdOp);
                    addr_d  = cmdAddr;
                    data_d  = cmdData;
                    idx_d   = 3'd0;
                    err_d   = 1'b0;
                    if (cmdOp == OP_HW_RESET) begin
                        frst_d = 1'b0;
                        cnt_d  = RST_CYC;
                        st_d   = HS_DELAY;
                    end else if ((cmdOp == OP_RESUME && !susp_q) ||
                            (cmdOp > OP_HW_RESET) ||
                            (cmdOp == OP_BYP_PROG && !byp_q) ||
                            (byp_q && cmdOp != OP_BYP_PROG &&
                             cmdOp != OP_BYP_EXIT && cmdOp != OP_READ)) begin
                        // Would be discarded by the device; never sent
                        err_d   = 1'b1;
                        rspV_d  = 1'b1;
                        ready_d = 1'b1;
                    end else begin
                        st_d = HS_ISSUE;
                    end
                end
            end
            HS_ISSUE: begin
                req_d = 1'b1;
                st_d  = HS_WAIT;
            end
            HS_WAIT: begin
                if (cyc.done) begin
                    // Reads in erasing sectors simply return status bits
                    if (step.isRead) rdat_d = cyc.rdData;
                    if (!step.last) begin
                        idx_d = idx_q + 3'd1;
                        st_d  = HS_ISSUE;
                    end else if (op_q == OP_SUSPEND) begin
                        // Worst-case latency covers the time-out case too
                        cnt_d = SUSP_CYC;
                        st_d  = HS_DELAY;
                    end else begin
                        if (op_q == OP_RESUME) susp_d = 1'b0;
                        if (op_q == OP_BYP_ENT) byp_d = 1'b1;
                        if (op_q == OP_BYP_EXIT) byp_d = 1'b0;
                        rspV_d  = 1'b1;
                        ready_d = 1'b1;
                        st_d    = HS_IDLE;
                    end
                end
            end
            HS_DELAY: begin
                cnt_d = cnt_q - 11'h001;
                if (cnt_q == 11'h001) begin
                    if (op_q == OP_HW_RESET) begin
                        frst_d = 1'b1;
                        susp_d = 1'b0;
                        byp_d  = 1'b0;
                    end else begin
                        // Chip erase or program leaves the device busy
                        susp_d = 1'b1;
                    end
                    rspV_d  = 1'b1;
                    ready_d = 1'b1;
                    st_d    = HS_IDLE;
                end
            end
            default: st_d = HS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= HS_IDLE; op_q <= OP_READ; idx_q <= 3'd0;
            addr_q <= 22'h000000; data_q <= 8'h00; rdat_q <= 8'h00;
            cnt_q <= 11'h000; susp_q <= 1'b0; byp_q <= 1'b0;
            ready_q <= 1'b1; rspV_q <= 1'b0; err_q <= 1'b0;
            req_q <= 1'b0; frst_q <= 1'b1;
        end else begin
            st_q <= st_d; op_q <= op_d; idx_q <= idx_d;
            addr_q <= addr_d; data_q <= data_d; rdat_q <= rdat_d;
            cnt_q <= cnt_d; susp_q <= susp_d; byp_q <= byp_d;
            ready_q <= ready_d; rspV_q <= rspV_d; err_q <= err_d;
            req_q <= req_d; frst_q <= frst_d;
        end
    end

    // Step fields are steady while a cycle runs, since idx only moves on done
    assign cyc.reqValid = req_q;
    assign cyc.reqRead  = step.isRead;
    assign cyc.reqAddr  = step.addr;
    assign cyc.reqData  = step.data;

    fsc_bus_cycle u_cycle (
        .core_clk  (core_clk),
        .rst       (rst),
        .cyc       (cyc),
        .flashAddr (flashAddr),
        .dqIn      (dqIn),
        .dqOut     (dqOut),
        .dqOeN     (dqOeN),
        .ceN       (ceN),
        .weN       (weN),
        .oeN       (oeN)
    );

    assign cmdReady       = ready_q;
    assign rspValid       = rspV_q;
    assign rspErr         = err_q;
    assign rspData        = rdat_q;
    assign eraseSuspended = susp_q;
    assign bypassActive   = byp_q;
    assign flashRstN      = frst_q;
endmodule : fsc_host_ctrl

// File: testbench/fsc_host_ctrl_chk.sv
// Checker of the flash host pins and of the command port handshake.
// Assumes it is bound to fsc_host_ctrl and sees only that module's ports.
`timescale 1ns/100ps
module fsc_host_ctrl_chk
    import fsc_pkg::*;
(
    input logic core_clk,
    input logic rst,
    input logic cmdReady,
    input logic rspValid,
    input logic rspErr,
    input logic eraseSuspended,
    input logic dqOeN,
    input logic ceN,
    input logic weN,
    input logic oeN,
    input logic flashRstN
);
    logic [11:0] sinceWe_q, sinceWe_d;
    logic [11:0] sinceRst_q, sinceRst_d;

    // Cycles since the strobe and the reset pin were last low, saturating
    always_comb begin
        sinceWe_d  = sinceWe_q + {11'h0, sinceWe_q != 12'hFFF};
        sinceRst_d = sinceRst_q + {11'h0, sinceRst_q != 12'hFFF};
        if (!weN) sinceWe_d = 12'h0;
        if (!flashRstN) sinceRst_d = 12'h0;
    end

    // Registers of the helper counters
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sinceWe_q  <= 12'h0;
            sinceRst_q <= 12'h0;
        end else begin
            sinceWe_q  <= sinceWe_d;
            sinceRst_q <= sinceRst_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Write strobe: three cycles low, data still held as it rises
    sequence weStrobe;
        !weN [*3] ##1 weN;
    endsequence
    sequence dataHeld;
        !ceN && !dqOeN;
    endsequence

    AST_WE_CYCLE: assert property ($fell(weN) |-> weStrobe ##0 dataHeld)
        else $error("write strobe width or data hold wrong");
    AST_WE_NEEDS_CE: assert property (!weN |-> !ceN && !dqOeN && oeN)
        else $error("write strobe without chip select or data");
    AST_OE_NOT_WE: assert property (!oeN |-> weN && dqOeN && !ceN)
        else $error("read strobe with host driving data");
    AST_READY_ON_RSP: assert property (rspValid |-> cmdReady)
        else $error("response while not ready");
    AST_BUSY_PINS: assert property (!ceN |-> !cmdReady)
        else $error("pin activity while idle");
    AST_ERR_NO_PIN: assert property (rspValid && rspErr |->
        ceN && $past(ceN) && $past(ceN, 2))
        else $error("refused command touched the pins");
    AST_SUSPEND_WAIT: assert property ($rose(eraseSuspended) |->
        sinceWe_q >= SUSP_CYC - 11'd1)
        else $error("suspended flag set before latency ran out");
    AST_RESUME_CLEARS: assert property ($fell(eraseSuspended) |->
        !flashRstN || sinceWe_q < 12'h8 || sinceRst_q < 12'h8)
        else $error("suspended flag cleared without resume or reset");
    AST_RST_PULSE: assert property ($fell(flashRstN) |->
        (!flashRstN && ceN && weN) [*8])
        else $error("hardware reset pulse too short or busy");
endmodule : fsc_host_ctrl_chk

bind fsc_host_ctrl fsc_host_ctrl_chk chk_u (
    .core_clk(core_clk), .rst(rst), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspErr(rspErr), .eraseSuspended(eraseSuspended),
    .dqOeN(dqOeN), .ceN(ceN), .weN(weN), .oeN(oeN), .flashRstN(flashRstN)
);

// File: testbench/fsc_flash_model.sv
// Behavioural byte-wide NOR flash: command decode, suspend, autoselect.
// Assumes the host pins of fsc_host_ctrl; erases never end by themselves.
`timescale 1ns/100ps
module fsc_flash_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5E, // Arbitrary value
    parameter logic [7:0] PART_CODE  = 8'h7C, // Arbitrary value
    parameter int         ACC_NS     = 40
) (
    input  wire logic [21:0] flashAddr,
    input  wire logic [7:0]  dqOut,
    input  wire logic        dqOeN,
    input  wire logic        ceN,
    input  wire logic        weN,
    input  wire logic        oeN,
    input  wire logic        flashRstN,
    output wire logic [7:0]  dqIn
);
    logic [7:0] mem [int];
    logic [7:0] rdVal = 8'h00;
    logic [5:0] eraseSec = 6'h00;
    logic [3:0] phase = 4'h0;
    logic       susp = 1'h0, erasing = 1'h0, chipBusy = 1'h0;
    logic       autosel = 1'h0, bypass = 1'h0;

    // Read answer: codes, status bytes or array contents
    function automatic logic [7:0] rd_val(input logic [21:0] a);
        if (autosel) // Codes live outside the array
            return a[7:0] == 8'h00 ? MAKER_CODE : a[7:0] == 8'h01 ?
                   PART_CODE : a[7:0] == 8'h06 ? 8'h85 : 8'h00;
        if (chipBusy || (erasing && !susp))
            return 8'h00; // Poll bit low while erasing
        if (erasing && a[21:16] == eraseSec)
            return 8'h84; // Poll bit high when suspended
        return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
    endfunction : rd_val

    // Command decode on the strobe's rise; a hardware reset aborts all
    always @(posedge weN or negedge flashRstN) begin
        if (!flashRstN)
            {phase, susp, erasing, chipBusy, autosel, bypass} = '0;
        else if (!ceN && !dqOeN) begin
            if (chipBusy || (erasing && !susp && dqOut != 8'hB0))
                phase = 4'h0; // Busy: all else ignored
            else case (phase)
                4'h0: if (dqOut == 8'hF0) autosel = 1'h0;
                    else if (dqOut == 8'hB0) susp = erasing;
                    else if (dqOut == 8'h30) susp = 1'h0;
                    else if (dqOut == 8'hAA) phase = 4'h1;
                4'h1: phase = dqOut == 8'h55 ? 4'h2 : 4'h0;
                4'h2: begin // Third cycle; 88 enters nothing modelled
                    phase = dqOut == 8'hA0 ? 4'h6 : dqOut == 8'h80 ? 4'h3 :
                            dqOut == 8'h20 ? 4'h7 : 4'h0;
                    autosel = dqOut == 8'h90 && !flashAddr[21];
                    bypass = dqOut == 8'h20;
                end
                4'h3: phase = dqOut == 8'hAA ? 4'h4 : 4'h0;
                4'h4: phase = dqOut == 8'h55 ? 4'h5 : 4'h0;
                4'h5: begin // Sixth erase cycle
                    chipBusy = dqOut == 8'h10;
                    erasing = dqOut == 8'h30;
                    eraseSec = flashAddr[21:16];
                    phase = 4'h0;
                end
                4'h6: begin // Program target
                    mem[int'(flashAddr)] = dqOut;
                    phase = bypass ? 4'h7 : 4'h0;
                end
                4'h7: phase = dqOut == 8'hA0 ? 4'h6 :
                              dqOut == 8'h90 ? 4'h8 : 4'h7;
                default: begin // Leaving bypass needs 00
                    bypass = dqOut != 8'h00;
                    phase = bypass ? 4'h7 : 4'h0;
                end
            endcase
        end
    end

    // Released bus shows the inverse byte, never a stale copy
    always @* if (!ceN && !oeN) rdVal = rd_val(flashAddr);
    assign #(ACC_NS) dqIn = (!ceN && !oeN) ? rdVal : ~rdVal;
endmodule : fsc_flash_model

// File: testbench/test_flash_erase_suspend_cmd_decoder.sv
// Self-checking bench of fsc_host_ctrl driving a behavioural flash.
// Assumes the model and checker files are compiled before this one.
`timescale 1ns/100ps
module test_flash_erase_suspend_cmd_decoder
    import fsc_pkg::*;
;
    localparam logic [21:0] SEC_A = 22'h050000;
    localparam logic [7:0]  MAKER = 8'h5E; // Arbitrary
    localparam logic [7:0]  PART  = 8'h7C; // Arbitrary
    typedef struct {
        logic [3:0] op; logic [21:0] a; logic [7:0] d;
        logic [2:0] f; logic [7:0] exp; // Flags: err, byp, chk
    } fsc_row_t;
    logic        core_clk = 1'h0, rst = 1'h1, cmdValid = 1'h0;
    logic [3:0]  cmdOp = 4'h0;
    logic [21:0] cmdAddr = 22'h0, flashAddr;
    logic [7:0]  cmdData = 8'h00, rspData, dqIn, dqOut, gotData;
    logic        cmdReady, rspValid, rspErr, eraseSuspended, bypassActive;
    logic        dqOeN, ceN, weN, oeN, flashRstN, gotErr;
    int          mismatches = 0, checks_done = 0;
    fsc_row_t    rows [16];

    always #10 core_clk = ~core_clk;

    fsc_host_ctrl dut_u (.core_clk(core_clk), .rst(rst),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
        .rspErr(rspErr), .rspData(rspData), .eraseSuspended(eraseSuspended),
        .bypassActive(bypassActive), .flashAddr(flashAddr), .dqIn(dqIn),
        .dqOut(dqOut), .dqOeN(dqOeN), .ceN(ceN), .weN(weN), .oeN(oeN),
        .flashRstN(flashRstN));
    fsc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_u (
        .flashAddr(flashAddr), .dqOut(dqOut), .dqOeN(dqOeN), .ceN(ceN),
        .weN(weN), .oeN(oeN), .flashRstN(flashRstN), .dqIn(dqIn));

    // Compare one value and count it
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One command, then wait for its response pulse
    task automatic do_op(input logic [3:0] op, input logic [21:0] a = 22'h0,
                         input logic [7:0] d = 8'h00);
        int n = 0;
        cmdOp    <= op;
        cmdAddr  <= a;
        cmdData  <= d;
        cmdValid <= 1'h1;
        @(posedge core_clk);
        cmdValid <= 1'h0;
        do begin
            @(negedge core_clk);
            n++;
        end while (rspValid !== 1'h1 && n < 3000);
        if (n >= 3000) begin
            mismatches++;
            $display("BAD %0t no response", $time);
        end
        gotData = rspData;
        gotErr  = rspErr;
        @(posedge core_clk);
    endtask : do_op

    // Verdict and end of run
    task end_sim;
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // Watchdog well beyond the expected few thousand cycles
    initial begin
        repeat (40000) @(posedge core_clk);
        mismatches++;
        end_sim();
    end

    // Table of plain cases, then the awkward ones
    initial begin
        rows = '{
            '{OP_PROGRAM, 22'h001234, 8'hA5, 3'h0, 8'h0},
            '{OP_READ, 22'h001234, 8'h0, 3'h1, 8'hA5},
            '{OP_AUTOSEL, 22'h0, 8'h0, 3'h1, MAKER},
            '{OP_AUTOSEL, 22'h1, 8'h0, 3'h1, PART},
            '{OP_AUTOSEL, 22'h6, 8'h0, 3'h1, 8'h85},
            '{OP_SECURED, 22'h0, 8'h0, 3'h0, 8'h0},
            '{OP_RESET, 22'h0, 8'h0, 3'h0, 8'h0},
            '{OP_BYP_ENT, 22'h0, 8'h0, 3'h2, 8'h0},
            '{OP_BYP_PROG, 22'h10, 8'h3C, 3'h2, 8'h0},
            '{OP_READ, 22'h10, 8'h0, 3'h3, 8'h3C},
            '{OP_PROGRAM, 22'h1111, 8'h11, 3'h6, 8'h0},
            '{OP_BYP_EXIT, 22'h0, 8'h0, 3'h0, 8'h0},
            '{OP_BYP_PROG, 22'h10, 8'h3C, 3'h4, 8'h0},
            '{OP_RESUME, 22'h0, 8'h0, 3'h4, 8'h0},
            '{4'hD, 22'h0, 8'h0, 3'h4, 8'h0},
            '{OP_READ, 22'h001234, 8'h0, 3'h1, 8'hA5}};
        repeat (10) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        foreach (rows[i]) begin
            do_op(rows[i].op, rows[i].a, rows[i].d);
            check({7'h0, gotErr}, {7'h0, rows[i].f[2]});
            check({7'h0, bypassActive}, {7'h0, rows[i].f[1]});
            if (rows[i].f[0])
                check(gotData, rows[i].exp);
        end
        // Suspend caught inside the acceptance time-out
        do_op(OP_SECT_ER, SEC_A);
        do_op(OP_SUSPEND, 22'h3FFFFF);
        check({7'h0, eraseSuspended}, 8'h1);
        do_op(OP_READ, SEC_A + 22'h5);
        check({7'h0, gotData[7]}, 8'h1);
        do_op(OP_READ, 22'h001234);
        check(gotData, 8'hA5);
        do_op(OP_PROGRAM, 22'h002000, 8'h5A);
        do_op(OP_READ, 22'h002000);
        check(gotData, 8'h5A);
        do_op(OP_AUTOSEL, SEC_A);
        check(gotData, MAKER);
        do_op(OP_READ, SEC_A);
        check({7'h0, gotData[7]}, 8'h1);
        do_op(OP_RESUME);
        check({gotErr, 6'h0, eraseSuspended}, 8'h0);
        do_op(OP_READ, SEC_A);
        check({7'h0, gotData[7]}, 8'h0);
        do_op(OP_RESUME);
        check({7'h0, gotErr}, 8'h1);
        do_op(OP_SUSPEND);
        do_op(OP_READ, SEC_A);
        check({7'h0, gotData[7]}, 8'h1);
        // Hardware reset aborts the suspended erase
        do_op(OP_HW_RESET);
        check({6'h0, eraseSuspended, bypassActive}, 8'h0);
        do_op(OP_READ, SEC_A);
        check(gotData, 8'hFF);
        // Chip erase keeps running through a suspend
        do_op(OP_CHIP_ER);
        do_op(OP_SUSPEND);
        do_op(OP_READ, 22'h001234);
        check({7'h0, gotData[7]}, 8'h0);
        do_op(OP_HW_RESET);
        // Core reset in mid-run, then a request at the first edge after
        rst <= 1'h1;
        @(negedge core_clk);
        check({4'h0, cmdReady, ceN, weN, flashRstN}, 8'h0F);
        check({6'h0, rspValid, eraseSuspended}, 8'h0);
        @(posedge core_clk);
        rst <= 1'h0;
        do_op(OP_READ, 22'h001234);
        check(gotData, 8'hA5);
        end_sim();
    end
endmodule : test_flash_erase_suspend_cmd_decoder
